// >>> rtl/cmc_regs.svh
`ifndef CMC_REGS_SVH
`define CMC_REGS_SVH

// register offsets (one register per address, 8-bit data)
`define CMC_ADDR_W 3
`define CMC_A_STATUS 3'h0
`define CMC_A_CTRL 3'h1
`define CMC_A_CURR 3'h2
`define CMC_A_CHRG 3'h3
`define CMC_A_IDENT 3'h4
`define CMC_A_UPSTR 3'h5
`define CMC_A_DNSTR 3'h6

// reset values
`define CMC_CTRL_RST 8'h84
`define CMC_CURR_RST 8'hFB
`define CMC_CHRG_RST 8'h89
`define CMC_UPSTR_RST 8'h00
`define CMC_DNSTR_RST 8'h00
`define CMC_IDENT_VAL 8'h5A

// status register fields
`define CMC_ST_SWRST 7
`define CMC_ST_BOOST 6
`define CMC_ST_CHG_HI 5
`define CMC_ST_CHG_LO 4
`define CMC_ST_LLOAD 3
`define CMC_ST_BATDPL 2
`define CMC_ST_VREG 1
`define CMC_ST_VINPRES 0

// control register fields
`define CMC_CT_CHG_EN 7
`define CMC_CT_SUPP_EN 6
`define CMC_CT_OSE 5
`define CMC_CT_RSVD 4
`define CMC_CT_TMR_HI 2
`define CMC_CT_TMR_LO 1
`define CMC_CT_TERM 0

// downstream register fields
`define CMC_DN_OVR 5
`define CMC_DN_HVALLOW 4
`define CMC_DN_UPNEG 3

// charge state codes
`define CMC_CHG_READY 2'h0
`define CMC_CHG_BUSY 2'h1
`define CMC_CHG_DONE 2'h2
`define CMC_CHG_FAULT 2'h3

// charge timeout field codes and lengths in seconds
`define CMC_TMR_5H 2'h0
`define CMC_TMR_10H 2'h1
`define CMC_TMR_20H 2'h2
`define CMC_TMR_5H_S 17'h04650
`define CMC_TMR_10H_S 17'h08CA0
`define CMC_TMR_20H_S 17'h11940

// times and their cycle counts at the core clock
`define CMC_CLK_HZ 50000000
`define CMC_T_DETECT_MS 100
`define CMC_T_EVENT_US 200
`define CMC_BLINK_HZ 10
`define CMC_T_RETRY_MS 5
`define CMC_T_RETRY_PER_MS 600
`define CMC_DETECT_CYC (`CMC_T_DETECT_MS * (`CMC_CLK_HZ / 1000))
`define CMC_EVENT_CYC (`CMC_T_EVENT_US * (`CMC_CLK_HZ / 1000000))
`define CMC_BLINK_CYC (`CMC_CLK_HZ / (2 * `CMC_BLINK_HZ))
`define CMC_RETRY_CYC (`CMC_T_RETRY_MS * (`CMC_CLK_HZ / 1000))
`define CMC_RETRY_PER_CYC (`CMC_T_RETRY_PER_MS * (`CMC_CLK_HZ / 1000))
`define CMC_SEC_CYC (`CMC_CLK_HZ)

`endif

// >>> rtl/cmc_pkg.sv
package cmc_pkg;
  // input-power sequencing modes
  typedef enum logic [1:0] {
    MD_OFF,
    MD_DETECT,
    MD_BC12,
    MD_ACTIVE
  } cmc_mode_t;
endpackage

// >>> rtl/cmc_charger_ctrl.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "cmc_regs.svh"

// How it works
// R1: input present, no fault: buck charging
// R2: boost only above depletion; below, everything off (supplement-mode boost is not gated by depletion)
// R3: sink input 100ms, then flag presence
// R4: run port detection, pulse event, record type
// R5: drive data-line level, report negative line
// R6: high-voltage allow plus 9V/12V select moves points
// R7: charger enable bit gates charging
// R8: event pulse on each detection and change
// R9: input current limit field to regulator
// R10: input voltage point field, regulating flag
// R11: output current limit field to regulator
// R12: charge current, voltage and termination fields
// R13: light load drives pin and flag
// R14: supplement mode switches buck to boost
// R15: output supply needs pin and bit
// R16: override bit makes boost voltage writable
// R17: faults clear output supply enable bit
// R18: status pin low, high or 10Hz blink
// R19: thermal fault pauses timer, keeps count
// R20: short retries 5ms every 0.6s, foldback
// R21: overvoltage stops switching until normal
// R22: timeout latches off until input replug
// R23: timer field 5h, 10h, 20h, disabled
// R24: charge state encoding ready/busy/done/fault
module cmc_charger_ctrl import cmc_pkg::*; #(
  parameter logic [31:0] DETECT_CYC = `CMC_DETECT_CYC,
  parameter logic [31:0] EVENT_CYC = `CMC_EVENT_CYC,
  parameter logic [31:0] BLINK_CYC = `CMC_BLINK_CYC,
  parameter logic [31:0] RETRY_CYC = `CMC_RETRY_CYC,
  parameter logic [31:0] RETRY_PER_CYC = `CMC_RETRY_PER_CYC,
  parameter logic [31:0] SEC_CYC = `CMC_SEC_CYC,
  parameter logic [7:0] IDENT = `CMC_IDENT_VAL // arbitrary identity value
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [`CMC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // analog comparators and pins, all asynchronous
  input wire logic vin_above_uvlo_i,
  input wire logic bat_above_dep_i,
  input wire logic bus_ovp_i,
  input wire logic bat_ovp_i,
  input wire logic vin_ovp_i,
  input wire logic cold_fault_i,
  input wire logic hot_fault_i,
  input wire logic thermal_shutdown_i,
  input wire logic bat_short_i,
  input wire logic sys_short_i,
  input wire logic in_vreg_active_i,
  input wire logic light_load_i,
  input wire logic buck_duty_zero_i,
  input wire logic load_rising_i,
  input wire logic charge_done_i,
  input wire logic output_supply_enable_pin_i,
  input wire logic upstream_data_neg_i,
  input wire logic bc_done_i,
  input wire logic [1:0] bc_type_i,
  input wire logic ds_done_i,
  input wire logic [1:0] ds_req_i,
  // power stage control
  output logic buck_en_o,
  output logic boost_en_o,
  output logic output_linear_switch_o,
  output logic in_sink_o,
  output logic bc_detect_o,
  output logic foldback_o,
  // regulation setpoints
  output logic [2:0] in_ilim_o,
  output logic [2:0] input_voltage_regulation_o,
  output logic [2:0] out_ilim_o,
  output logic [2:0] chg_cur_o,
  output logic [1:0] chg_volt_o,
  output logic termination_current_o,
  output logic [1:0] light_load_threshold_o,
  output logic [1:0] hv_sel_o,
  output logic [3:0] upstream_data_pos_o,
  output logic [1:0] boost_vout_o,
  // host event and open-drain indicators
  output logic event_n_o,
  output logic stat_o,
  output logic stat_oe_n_o,
  output logic light_load_pin_o,
  output logic light_load_pin_oe_n_o
);

  // synchroniser bit positions
  localparam int NSYNC = 23;
  localparam int I_VIN = 0;
  localparam int I_BDEP = 1;
  localparam int I_BUSOVP = 2;
  localparam int I_BATOVP = 3;
  localparam int I_VINOVP = 4;
  localparam int I_COLD = 5;
  localparam int I_HOT = 6;
  localparam int I_TSD = 7;
  localparam int I_BSHORT = 8;
  localparam int I_SSHORT = 9;
  localparam int I_VREG = 10;
  localparam int I_LIGHT = 11;
  localparam int I_DZERO = 12;
  localparam int I_LRISE = 13;
  localparam int I_CDONE = 14;
  localparam int I_OSE = 15;
  localparam int I_UPNEG = 16;
  localparam int I_BCDONE = 17;
  localparam int I_BCTYPE = 18;
  localparam int I_DSDONE = 20;
  localparam int I_DSREQ = 21;

  // refuse counts that the counters cannot serve
  if (DETECT_CYC == 0 || EVENT_CYC == 0 || BLINK_CYC == 0 || SEC_CYC == 0 ||
      RETRY_CYC == 0 || RETRY_PER_CYC <= RETRY_CYC) begin : g_bad_cfg
    $error("cmc_charger_ctrl: invalid timing parameters");
  end

  // whole module state
  typedef struct packed {
    logic [NSYNC-1:0] s1; // first sync stage, read only by s2
    logic [NSYNC-1:0] s2; // synchronised inputs
    cmc_mode_t mode;
    logic [31:0] det_cnt; // input sink timer
    logic [31:0] evt_cnt; // event pulse remaining
    logic [31:0] blink_cnt; // half-period counter
    logic [31:0] sc_cnt; // short retry phase
    logic [31:0] sec_cnt; // second prescaler
    logic [16:0] tmr_s; // charge seconds
    logic present; // input confirmed
    logic timeout; // timer latch
    logic blink; // 10Hz square wave
    logic ds_done_d; // edge detect of downstream done
    logic ds_seen; // downstream detection done once
    logic [1:0] ds_last; // last downstream level
    logic [7:0] ctrl;
    logic [7:0] curr;
    logic [7:0] chrg;
    logic [7:0] upstr;
    logic [7:0] dnstr;
    logic [1:0] hv; // high-voltage select handed to the regulator
    logic [1:0] chg_st;
    logic boost_md;
    logic [7:0] rdata;
    logic buck;
    logic boost;
    logic lin;
    logic sink;
    logic bc_req;
    logic fold;
    logic evt_n;
    logic stat_oe_n;
    logic lls_oe_n;
  } cmc_state_t;

  cmc_state_t q;
  cmc_state_t n;

  // synchronised views
  logic vin, bat_dep_ok, bus_ovp, bat_ovp, vin_ovp, thermal, bat_short, sys_short;
  logic vreg, light, duty_zero, load_rise, chg_done, ose_pin, up_neg, bc_done, ds_done;
  logic [1:0] bc_type, ds_req;
  assign vin = q.s2[I_VIN];
  assign bat_dep_ok = q.s2[I_BDEP];
  assign bus_ovp = q.s2[I_BUSOVP];
  assign bat_ovp = q.s2[I_BATOVP];
  assign vin_ovp = q.s2[I_VINOVP];
  assign thermal = q.s2[I_COLD] | q.s2[I_HOT] | q.s2[I_TSD];
  assign bat_short = q.s2[I_BSHORT];
  assign sys_short = q.s2[I_SSHORT];
  assign vreg = q.s2[I_VREG];
  assign light = q.s2[I_LIGHT];
  assign duty_zero = q.s2[I_DZERO];
  assign load_rise = q.s2[I_LRISE];
  assign chg_done = q.s2[I_CDONE];
  assign ose_pin = q.s2[I_OSE];
  assign up_neg = q.s2[I_UPNEG];
  assign bc_done = q.s2[I_BCDONE];
  assign ds_done = q.s2[I_DSDONE];
  assign bc_type = q.s2[I_BCTYPE +: 2];
  assign ds_req = q.s2[I_DSREQ +: 2];

  // timer field to limit in seconds, zero means disabled
  function automatic logic [16:0] tmr_limit(input logic [1:0] sel);
    case (sel)
      `CMC_TMR_5H: tmr_limit = `CMC_TMR_5H_S; // [R23]
      `CMC_TMR_10H: tmr_limit = `CMC_TMR_10H_S; // [R23]
      `CMC_TMR_20H: tmr_limit = `CMC_TMR_20H_S; // [R23]
      default: tmr_limit = 17'h0; // [R23]
    endcase
  endfunction

  // next-state logic
  always_comb begin
    logic ose_on, charging, supp, dischg, chg_fault, trig, retry, ovp_stop;
    logic [16:0] lim;
    n = q;
    ose_on = 1'b0;
    charging = 1'b0;
    supp = 1'b0;
    dischg = 1'b0;
    chg_fault = 1'b0;
    trig = 1'b0;
    retry = 1'b0;
    ovp_stop = 1'b0;
    lim = tmr_limit(q.ctrl[`CMC_CT_TMR_HI:`CMC_CT_TMR_LO]);
    n.s1 = {ds_req_i, ds_done_i, bc_type_i, bc_done_i, upstream_data_neg_i,
            output_supply_enable_pin_i, charge_done_i, load_rising_i, buck_duty_zero_i,
            light_load_i, in_vreg_active_i, sys_short_i, bat_short_i, thermal_shutdown_i,
            hot_fault_i, cold_fault_i, vin_ovp_i, bat_ovp_i, bus_ovp_i, bat_above_dep_i,
            vin_above_uvlo_i};
    n.s2 = q.s1;

    // host writes; reserved bits stay zero
    if (reg_wr_i) begin
      case (reg_addr_i)
        `CMC_A_STATUS: begin
          if (reg_wdata_i[`CMC_ST_SWRST]) begin // self-clearing parameter reset
            n.ctrl = `CMC_CTRL_RST;
            n.curr = `CMC_CURR_RST;
            n.chrg = `CMC_CHRG_RST;
            n.upstr = `CMC_UPSTR_RST;
            n.dnstr = `CMC_DNSTR_RST;
          end
        end
        `CMC_A_CTRL: n.ctrl = reg_wdata_i & ~(8'h01 << `CMC_CT_RSVD);
        `CMC_A_CURR: n.curr = reg_wdata_i;
        `CMC_A_CHRG: n.chrg = reg_wdata_i;
        `CMC_A_UPSTR: n.upstr[7:2] = reg_wdata_i[7:2];
        `CMC_A_DNSTR: begin
          n.dnstr[`CMC_DN_OVR:`CMC_DN_HVALLOW] = reg_wdata_i[`CMC_DN_OVR:`CMC_DN_HVALLOW];
          if (reg_wdata_i[`CMC_DN_OVR]) begin
            n.dnstr[7:6] = reg_wdata_i[7:6]; // [R16]
          end
        end
        default: ; // unmapped or read-only: ignored
      endcase
    end

    // downstream voltage follows the request unless overridden
    if (!n.dnstr[`CMC_DN_OVR]) begin
      n.dnstr[7:6] = ds_req; // [R16]
    end
    n.dnstr[`CMC_DN_UPNEG] = up_neg; // [R5]
    // registered so the pin never glitches while allow and select change
    n.hv = n.dnstr[`CMC_DN_HVALLOW] ? n.upstr[3:2] : 2'h0; // [R6]

    // input presence sequencing
    n.sink = 1'b0;
    n.bc_req = 1'b0;
    case (q.mode)
      MD_OFF: begin
        if (vin) begin
          n.mode = MD_DETECT;
          n.det_cnt = 32'h0;
          n.sink = 1'b1; // load starts with the mode, so it lasts the full count [R3]
        end
      end
      MD_DETECT: begin
        n.sink = 1'b1; // [R3]
        n.det_cnt = q.det_cnt + 32'h1;
        if (q.det_cnt == DETECT_CYC - 32'h1) begin
          n.mode = MD_BC12;
          n.present = 1'b1; // [R3]
          n.sink = 1'b0;
        end
      end
      MD_BC12: begin
        n.bc_req = 1'b1; // [R4]
        if (bc_done) begin
          n.upstr[1:0] = bc_type; // [R4]
          n.mode = MD_ACTIVE;
          n.bc_req = 1'b0;
          trig = 1'b1; // [R4] [R8]
        end
      end
      MD_ACTIVE: ;
      default: n.mode = MD_OFF;
    endcase
    // input lost: drop presence, replug clears the timeout latch
    if (!vin) begin
      n.mode = MD_OFF;
      n.present = 1'b0;
      n.sink = 1'b0;
      n.bc_req = 1'b0;
      n.timeout = 1'b0; // [R22]
      n.tmr_s = 17'h0;
      n.sec_cnt = 32'h0;
    end

    // downstream detection and later level changes
    n.ds_done_d = ds_done;
    n.ds_last = ds_req;
    if (ds_done && !q.ds_done_d) begin
      n.ds_seen = 1'b1;
      trig = 1'b1; // [R8]
    end else if (q.ds_seen && ds_req != q.ds_last) begin
      trig = 1'b1; // [R8]
    end

    // event pulse, retriggerable, low while counting
    if (trig) begin
      n.evt_cnt = EVENT_CYC;
    end else if (q.evt_cnt != 32'h0) begin
      n.evt_cnt = q.evt_cnt - 32'h1;
    end
    n.evt_n = (n.evt_cnt == 32'h0); // [R8]

    // output supply faults clear the enable bit; hardware wins over a write
    if (bat_ovp || thermal || !bat_dep_ok) begin
      n.ctrl[`CMC_CT_OSE] = 1'b0; // [R17]
    end

    // mode decisions
    ovp_stop = bus_ovp | bat_ovp; // [R21]
    ose_on = ose_pin & q.ctrl[`CMC_CT_OSE]; // [R15]
    charging = (q.mode == MD_ACTIVE) & q.ctrl[`CMC_CT_CHG_EN] & !q.timeout // [R1] [R7] [R22]
               & !thermal & !vin_ovp & !bat_ovp; // [R19]
    supp = (q.mode == MD_ACTIVE) & q.ctrl[`CMC_CT_SUPP_EN] & duty_zero & load_rise; // [R14]
    dischg = !q.present & !vin & ose_on & bat_dep_ok & !thermal; // [R2] [R15]
    n.buck = charging & !supp & !ovp_stop; // [R1] [R21]
    n.boost = (dischg | supp) & !ovp_stop; // [R2] [R14] [R21]
    n.boost_md = n.boost;
    n.fold = charging & bat_short; // [R20]

    // output short: retry window at the head of each period
    if (sys_short) begin
      n.sc_cnt = (q.sc_cnt == RETRY_PER_CYC - 32'h1) ? 32'h0 : q.sc_cnt + 32'h1;
      retry = (q.sc_cnt < RETRY_CYC); // [R20]
    end else begin
      n.sc_cnt = 32'h0;
    end
    n.lin = ose_on & (q.present | dischg) & bat_dep_ok & (!sys_short | retry); // [R2] [R15] [R20]

    // charge timer counts whole seconds, paused while not charging
    if (charging && !chg_done && lim != 17'h0 && !q.timeout) begin
      if (q.sec_cnt == SEC_CYC - 32'h1) begin
        n.sec_cnt = 32'h0;
        n.tmr_s = q.tmr_s + 17'h1;
      end else begin
        n.sec_cnt = q.sec_cnt + 32'h1;
      end
    end // thermal fault leaves sec_cnt and tmr_s untouched [R19]
    if (lim != 17'h0 && q.tmr_s >= lim) begin
      n.timeout = 1'b1; // [R22]
    end

    // charge state
    chg_fault = q.present & (vin_ovp | bat_ovp | bat_short | thermal | q.timeout);
    if (chg_fault) begin
      n.chg_st = `CMC_CHG_FAULT; // [R24]
    end else if (charging && chg_done) begin
      n.chg_st = `CMC_CHG_DONE; // [R24]
    end else if (charging) begin
      n.chg_st = `CMC_CHG_BUSY; // [R24]
    end else begin
      n.chg_st = `CMC_CHG_READY; // [R24]
    end

    // 10Hz blink source
    if (q.blink_cnt == BLINK_CYC - 32'h1) begin
      n.blink_cnt = 32'h0;
      n.blink = ~q.blink;
    end else begin
      n.blink_cnt = q.blink_cnt + 32'h1;
    end

    // status pin: pull low when busy, blink on fault, else released
    case (n.chg_st)
      `CMC_CHG_BUSY: n.stat_oe_n = 1'b0; // [R18]
      `CMC_CHG_FAULT: n.stat_oe_n = q.blink; // [R18]
      default: n.stat_oe_n = 1'b1; // [R18]
    endcase
    n.lls_oe_n = ~light; // [R13]

    // read data, valid only in the cycle after the strobe
    n.rdata = 8'h00;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `CMC_A_STATUS: n.rdata = {1'b0, q.boost_md, q.chg_st, light, ~bat_dep_ok, vreg, q.present}; // [R3] [R10] [R13]
        `CMC_A_CTRL: n.rdata = q.ctrl;
        `CMC_A_CURR: n.rdata = q.curr;
        `CMC_A_CHRG: n.rdata = q.chrg;
        `CMC_A_IDENT: n.rdata = IDENT;
        `CMC_A_UPSTR: n.rdata = q.upstr;
        `CMC_A_DNSTR: n.rdata = q.dnstr; // [R5]
        default: n.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.mode <= MD_OFF;
      q.ctrl <= `CMC_CTRL_RST;
      q.curr <= `CMC_CURR_RST;
      q.chrg <= `CMC_CHRG_RST;
      q.upstr <= `CMC_UPSTR_RST;
      q.dnstr <= `CMC_DNSTR_RST;
      q.evt_n <= 1'b1;
      q.stat_oe_n <= 1'b1;
      q.lls_oe_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register or tied low
  assign reg_rdata_o = q.rdata;
  assign buck_en_o = q.buck;
  assign boost_en_o = q.boost;
  assign output_linear_switch_o = q.lin;
  assign in_sink_o = q.sink;
  assign bc_detect_o = q.bc_req;
  assign foldback_o = q.fold;
  assign in_ilim_o = q.curr[7:5]; // [R9]
  assign input_voltage_regulation_o = q.chrg[7:5]; // [R10]
  assign out_ilim_o = q.curr[4:2]; // [R11]
  assign chg_cur_o = q.chrg[2:0]; // [R12]
  assign chg_volt_o = q.chrg[4:3]; // [R12]
  assign termination_current_o = q.ctrl[`CMC_CT_TERM]; // [R12]
  assign light_load_threshold_o = q.curr[1:0]; // [R13]
  assign hv_sel_o = q.hv; // [R6]
  assign upstream_data_pos_o = q.upstr[7:4]; // [R5]
  assign boost_vout_o = q.dnstr[7:6]; // [R16]
  assign event_n_o = q.evt_n;
  assign stat_o = 1'b0;
  assign stat_oe_n_o = q.stat_oe_n;
  assign light_load_pin_o = 1'b0;
  assign light_load_pin_oe_n_o = q.lls_oe_n;

endmodule

// >>> verification/cmc_bc_partner.sv
`timescale 1ns/1ps

// port detector on the far side: answers a detection request after a delay
module cmc_bc_partner #(
  parameter int DLY = 5 // cycles from request to answer
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic detect_i,
  input wire logic [1:0] type_sel_i,
  output logic done_o,
  output logic [1:0] type_o
);
  int cnt; // cycles since request
  // type settles before done; an idle line keeps changing, never holds the last value
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      done_o <= 1'h0;
      type_o <= 2'h0;
    end else if (!detect_i) begin
      cnt <= 0;
      done_o <= 1'h0;
      type_o <= ~type_o;
    end else if (cnt < DLY) begin
      cnt <= cnt + 1;
      type_o <= type_sel_i;
    end else begin
      done_o <= 1'h1;
    end
  end
endmodule

// >>> verification/cmc_charger_ctrl_assertions.sv
`timescale 1ns/1ps
`include "cmc_regs.svh"

// pin-level checks of the charger controller
module cmc_charger_ctrl_checker (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [`CMC_ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic vin_above_uvlo_i,
  input wire logic bat_above_dep_i,
  input wire logic bus_ovp_i,
  input wire logic bat_ovp_i,
  input wire logic light_load_i,
  input wire logic output_supply_enable_pin_i,
  input wire logic buck_en_o,
  input wire logic boost_en_o,
  input wire logic output_linear_switch_o,
  input wire logic in_sink_o,
  input wire logic [2:0] in_ilim_o,
  input wire logic [2:0] input_voltage_regulation_o,
  input wire logic [2:0] out_ilim_o,
  input wire logic [2:0] chg_cur_o,
  input wire logic [1:0] chg_volt_o,
  input wire logic termination_current_o,
  input wire logic [1:0] light_load_threshold_o,
  input wire logic event_n_o,
  input wire logic stat_o,
  input wire logic light_load_pin_o,
  input wire logic light_load_pin_oe_n_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // six samples cover the two or three cycles of synchroniser lag
  a_setpoint_reset: assert property (!$past(rst_n_i) |-> {in_ilim_o, out_ilim_o, light_load_threshold_o} == 8'hFB &&
    {input_voltage_regulation_o, chg_volt_o, chg_cur_o} == 8'h89 && !termination_current_o) else $error("setpoints off after reset");
  a_curr_write: assert property ($past(reg_wr_i, 2) && $past(reg_addr_i, 2) == `CMC_A_CURR && !$past(reg_wr_i) |->
    {in_ilim_o, out_ilim_o, light_load_threshold_o} == $past(reg_wdata_i, 2)) else $error("current limits not loaded");
  a_chrg_write: assert property ($past(reg_wr_i, 2) && $past(reg_addr_i, 2) == `CMC_A_CHRG && !$past(reg_wr_i) |->
    {input_voltage_regulation_o, chg_volt_o, chg_cur_o} == $past(reg_wdata_i, 2)) else $error("charge setpoints not loaded");
  a_event_width: assert property ($fell(event_n_o) |-> (!event_n_o)[*8]) else $error("event pulse short");
  a_ovp_stop: assert property ((bus_ovp_i || bat_ovp_i)[*6] |-> !buck_en_o && !boost_en_o) else $error("switching in overvoltage");
  a_vin_gone: assert property ((!vin_above_uvlo_i)[*6] |-> !buck_en_o && !in_sink_o) else $error("buck or sink without input");
  a_depletion_off: assert property ((!bat_above_dep_i)[*6] |-> !boost_en_o && !output_linear_switch_o) else $error("boost on empty cell");
  a_supply_gate: assert property ((!output_supply_enable_pin_i)[*6] |-> !output_linear_switch_o) else $error("switch closed, pin low");
  a_light_load: assert property ((!light_load_i)[*6] |-> light_load_pin_oe_n_o && !stat_o && !light_load_pin_o) else $error("light load pin");
endmodule

// >>> verification/cmc_charger_ctrl_test.sv
`timescale 1ns/1ps
`include "cmc_regs.svh"

// self-checking bench: host port, analog flags and a detector model
module cmc_charger_ctrl_test;
  logic core_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [`CMC_ADDR_W-1:0] reg_addr_i = '0;
  logic [7:0] reg_wdata_i = '0, reg_rdata_o;
  logic reg_wr_i = '0, reg_rd_i = '0, vin_above_uvlo_i = '0, bat_above_dep_i = '1, bus_ovp_i = '0, bat_ovp_i = '0;
  logic vin_ovp_i = '0, cold_fault_i = '0, hot_fault_i = '0, thermal_shutdown_i = '0, bat_short_i = '0, sys_short_i = '0;
  logic in_vreg_active_i = '0, light_load_i = '0, buck_duty_zero_i = '0, load_rising_i = '0, charge_done_i = '0;
  logic output_supply_enable_pin_i = '0, upstream_data_neg_i = '0, bc_done_i, ds_done_i = '0;
  logic [1:0] bc_type_i, ds_req_i = '0, type_sel = 2'h2;
  logic buck_en_o, boost_en_o, output_linear_switch_o, in_sink_o, bc_detect_o, foldback_o, termination_current_o;
  logic [2:0] in_ilim_o, input_voltage_regulation_o, out_ilim_o, chg_cur_o;
  logic [1:0] chg_volt_o, light_load_threshold_o, hv_sel_o, boost_vout_o;
  logic [3:0] upstream_data_pos_o;
  logic event_n_o, stat_o, stat_oe_n_o, light_load_pin_o, light_load_pin_oe_n_o;
  logic [7:0] d, rv [7] = '{8'h00, 8'h84, 8'hFB, 8'h89, 8'h5A, 8'h00, 8'h00}; // reset image
  int failures = 0, n_checks = 0, n;

  // short counts keep the run brief
  cmc_charger_ctrl #(.DETECT_CYC(20), .EVENT_CYC(8), .BLINK_CYC(4), .RETRY_CYC(3), .RETRY_PER_CYC(10), .SEC_CYC(2)) DUT (.*);
  cmc_bc_partner u_bc (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .detect_i(bc_detect_o), .type_sel_i(type_sel),
    .done_o(bc_done_i), .type_o(bc_type_i));

  initial forever #10 core_clk_i = ~core_clk_i;

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one-cycle strobes, launched on the edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_rd_i <= 1'h0;
    #1 check("register", e, reg_rdata_o & m);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk_i);
    #1;
  endtask
  // width of the next event pulse, bounded wait
  task automatic ev_len();
    for (int i = 0; i < 200 && event_n_o !== 1'h0; i++) cyc(1);
    n = 0;
    while (event_n_o === 1'h0 && n < 50) begin
      n++;
      cyc(1);
    end
    check("event cycles", 8'h08, n[7:0]);
  endtask
  // stat toggles every four cycles while blinking
  task automatic blink();
    n = 0;
    for (int i = 0; i < 40; i++) begin
      d[0] = stat_oe_n_o;
      cyc(1);
      if (stat_oe_n_o !== d[0]) n++;
    end
    check("blink", 8'h01, {7'h00, n inside {9, 10}});
  endtask
  task automatic power_up();
    vin_above_uvlo_i <= 1'h1;
    for (int i = 0; i < 50 && in_sink_o !== 1'h1; i++) cyc(1);
    n = 0;
    while (in_sink_o === 1'h1 && n < 100) begin
      n++;
      cyc(1);
    end
    check("sink cycles", 8'h14, n[7:0]);
    ev_len();
    cyc(4);
    check("buck", 8'h01, buck_en_o);
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog beyond the long timer scenario
  initial begin
    repeat (50000) @(posedge core_clk_i);
    failures++;
    close_out();
  end

  initial begin
    void'($urandom(32'hAFE3));
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'h1;
    cyc(3); // synchronisers fill before the first status read
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'hFF, a < 7 ? rv[a] : 8'h00);
    // random setpoints; reserved bit reads zero, ident ignores writes
    for (int a = 1; a < 4; a++) begin
      d = $urandom;
      wr(a[2:0], d);
      rd(a[2:0], 8'hFF, a == 1 ? d & 8'hEF : d);
    end
    wr(3'h1, 8'h85);
    cyc(1);
    check("term", 8'h01, {7'h00, termination_current_o});
    wr(3'h4, 8'hA5);
    rd(3'h4, 8'hFF, 8'h5A);
    wr(3'h0, 8'h80);
    rd(3'h2, 8'hFF, 8'hFB);
    wr(3'h5, 8'hA8);
    cyc(2);
    check("hv off", 8'h00, hv_sel_o);
    check("dpos", 8'h0A, upstream_data_pos_o);
    wr(3'h6, 8'h10);
    cyc(2);
    check("hv on", 8'h02, hv_sel_o);
    upstream_data_neg_i <= 1'h1;
    cyc(4);
    rd(3'h6, 8'h08, 8'h08);
    type_sel <= $urandom;
    power_up();
    rd(3'h0, 8'h31, 8'h11);
    rd(3'h5, 8'h03, {6'h00, type_sel});
    wr(3'h1, 8'h04);
    cyc(6);
    check("buck off", 8'h00, buck_en_o);
    wr(3'h1, 8'h84);
    cyc(6);
    check("buck on", 8'h01, buck_en_o);
    check("stat busy", 8'h00, stat_oe_n_o);
    for (int i = 0; i < 4; i++) begin
      {in_vreg_active_i, light_load_i} <= $urandom;
      cyc(6);
      rd(3'h0, 8'h0A, {4'h0, light_load_i, 1'h0, in_vreg_active_i, 1'h0});
      check("lls", {7'h00, ~light_load_i}, light_load_pin_oe_n_o);
    end
    charge_done_i <= 1'h1;
    cyc(6);
    rd(3'h0, 8'h30, 8'h20);
    check("stat done", 8'h01, stat_oe_n_o);
    charge_done_i <= 1'h0;
    // faults: battery overvoltage, input overvoltage, cold, hot, battery short, die overheating
    for (int k = 0; k < 6; k++) begin
      wr(3'h1, 8'hA4);
      {bat_ovp_i, vin_ovp_i, cold_fault_i, hot_fault_i, bat_short_i, thermal_shutdown_i} <= 6'h20 >> k;
      cyc(8);
      check("buck fault", {7'h00, k == 4}, buck_en_o);
      check("fold", {7'h00, k == 4}, foldback_o);
      blink();
      rd(3'h0, 8'h30, 8'h30);
      rd(3'h1, 8'h20, (k == 1 || k == 4) ? 8'h20 : 8'h00);
      {bat_ovp_i, vin_ovp_i, cold_fault_i, hot_fault_i, bat_short_i, thermal_shutdown_i} <= 6'h00;
      cyc(8);
    end
    wr(3'h1, 8'h84);
    // downstream detection and a level change both raise events
    ds_req_i <= $urandom;
    ds_done_i <= 1'h1;
    ev_len();
    rd(3'h6, 8'hC0, {ds_req_i, 6'h00});
    ds_req_i <= ~ds_req_i;
    ev_len();
    wr(3'h6, 8'h70);
    cyc(2);
    check("boost vout", 8'h01, boost_vout_o);
    wr(3'h1, 8'hC4);
    {buck_duty_zero_i, load_rising_i} <= 2'h3;
    cyc(8);
    check("supp", 8'h02, {boost_en_o, buck_en_o});
    {buck_duty_zero_i, load_rising_i} <= 2'h0;
    // shortest timer: 18000 s of two cycles
    wr(3'h1, 8'h80);
    cyc(36010);
    check("timeout", 8'h00, buck_en_o);
    rd(3'h0, 8'h30, 8'h30);
    vin_above_uvlo_i <= 1'h0;
    cyc(10);
    power_up();
    // discharge from the cell, then depletion
    vin_above_uvlo_i <= 1'h0;
    output_supply_enable_pin_i <= 1'h1;
    wr(3'h1, 8'hA4);
    cyc(8);
    check("boost", 8'h03, {boost_en_o, output_linear_switch_o});
    rd(3'h0, 8'h40, 8'h40);
    // output short: switch closes 3 of every 10 cycles
    sys_short_i <= 1'h1;
    cyc(4);
    n = 0;
    for (int i = 0; i < 20; i++) begin
      cyc(1);
      if (output_linear_switch_o === 1'h1) n++;
    end
    check("retry", 8'h06, n[7:0]);
    sys_short_i <= 1'h0;
    cyc(4);
    bat_above_dep_i <= 1'h0;
    cyc(8);
    rd(3'h1, 8'h20, 8'h00);
    close_out();
  end
endmodule

bind cmc_charger_ctrl cmc_charger_ctrl_checker u_chk (.*);
